/* verilog/ddcs_pkg.sv */
// Constants for the drive configuration, selection and start-up controller.
// Assumes a single 10 MHz clock and software access over APB.
// Summary of operation
// - A drive cabled radially sees itself selected at all times, whatever the select lines do.
// - Three switches are decoded: factory test or normal, motor control option, serial or step mode.
// - With five select positions, position five selects permanently and positions one to four set the chain address.
// - With the motor control option on, the spindle stays stopped after power-up until a motor-on command.
// - At power-up with motor control on, attention is raised and status bits 8 and 9 are set.
// - Once the spindle is in tolerance, 20 tuning seeks run and the heads go to cylinder 00.
// - In normal operation the indicator lights whenever the drive is selected.
// - The indicator flashes on a locked rotor, overspeed beyond 30 seconds, or 6 failed head loads.
package ddcs_pkg;
	localparam logic [11:0] DDCS_CTRL_ADDR     = 12'h000;
	localparam logic [11:0] DDCS_STATUS_ADDR   = 12'h004;
	localparam logic [11:0] DDCS_CMD_ADDR      = 12'h008;
	localparam logic [11:0] DDCS_CTRL_RESET    = 12'h004;
	localparam int          DDCS_CTRL_RADIAL   = 0;
	localparam int          DDCS_CTRL_TEST     = 1;
	localparam int          DDCS_CTRL_MOTOR    = 2;
	localparam int          DDCS_CTRL_SERIAL   = 3;
	localparam int          DDCS_CTRL_FIVE_POS = 4;
	localparam int          DDCS_CTRL_JUMPER   = 5;
	localparam int          DDCS_CMD_CLR_ATTN  = 0;
	localparam int          DDCS_CMD_MOTOR_ON  = 1;
	localparam int          DDCS_ST_POR_BIT    = 8;
	localparam int          DDCS_ST_STOP_BIT   = 9;
	localparam int          DDCS_ST_READY_BIT  = 0;
	localparam int          DDCS_ST_ATTN_BIT   = 1;
	localparam int          DDCS_ST_FAIL_BIT   = 2;
	localparam int          DDCS_ST_SEL_BIT    = 3;
	localparam int          DDCS_ST_SPIN_BIT   = 4;
	localparam int          DDCS_ST_SEEKS_LSB  = 16;
	localparam int          DDCS_ST_ADDR_LSB   = 24;
	localparam int          DDCS_MAX_SEEKS     = 20;
	localparam int          DDCS_LOAD_TRIES    = 6;
	localparam int          DDCS_CLK_HZ        = 10_000_000;
	localparam int          DDCS_OVERSPEED_S   = 30;
	localparam longint      DDCS_OVERSPEED_CYC = longint'(DDCS_OVERSPEED_S) * DDCS_CLK_HZ;
	localparam int          DDCS_FLASH_CYC     = 2_500_000;
	typedef enum logic [4:0] {
		DDCS_S_STOPPED = 5'b00001,
		DDCS_S_SPINUP  = 5'b00010,
		DDCS_S_TUNE    = 5'b00100,
		DDCS_S_LOAD    = 5'b01000,
		DDCS_S_READY   = 5'b10000
	} ddcs_state_t;
endpackage

/* verilog/ddcs_top.sv */
// Drive configuration, selection, power-up sequence and indicator control.
// Assumes APB master on i_clk, servo status inputs synchronous to i_clk.
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
module ddcs_top #(
	parameter int             SEL_W        = 4,
	parameter longint         OVERSPEED_CYC = ddcs_pkg::DDCS_OVERSPEED_CYC,
	parameter int             FLASH_CYC    = ddcs_pkg::DDCS_FLASH_CYC
) (
	input  wire logic             i_clk,
	input  wire logic             i_srst,
	input  wire logic             i_psel,
	input  wire logic             i_penable,
	input  wire logic             i_pwrite,
	input  wire logic [11:0]      i_paddr,
	input  wire logic [31:0]      i_pwdata,
	output logic                  o_pready,
	output logic                  o_pslverr,
	output logic [31:0]           o_prdata,
	input  wire logic [SEL_W-1:0] i_drive_select,
	input  wire logic             i_speed_ok,
	input  wire logic             i_overspeed,
	input  wire logic             i_rotor_locked,
	input  wire logic             i_seek_done,
	input  wire logic             i_head_load_ok,
	input  wire logic             i_head_load_fail,
	output logic                  o_attention,
	output logic                  o_ready,
	output logic                  o_selected,
	output logic                  o_spindle_on,
	output logic                  o_seek_start,
	output logic                  o_seek_to_zero,
	output logic                  o_head_load,
	output logic                  o_indicator,
	output logic                  o_factory_test,
	output logic                  o_serial_mode
);
	import ddcs_pkg::*;

	function automatic logic [2:0] ddcs_jumper_addr(input logic [2:0] j);
		ddcs_jumper_addr = (j > 3'h3) ? 3'h3 : j;
	endfunction

	logic [11:0] ctrl;
	logic [11:0] next_ctrl;
	logic        por;
	logic        next_por;
	logic        attn;
	logic        next_attn;
	logic        motor_cmd;
	logic        next_motor_cmd;
	ddcs_state_t state;
	ddcs_state_t next_state;
	logic [4:0]  seeks;
	logic [4:0]  next_seeks;
	logic [2:0]  tries;
	logic [2:0]  next_tries;
	logic        busy;
	logic        next_busy;
	logic        fail;
	logic        next_fail;
	logic [31:0] ospd_cnt;
	logic [31:0] next_ospd_cnt;
	logic [21:0] flash_cnt;
	logic [21:0] next_flash_cnt;
	logic        flash;
	logic        next_flash;
	logic        pready;
	logic        next_pready;
	logic        pslverr;
	logic        next_pslverr;
	logic [31:0] prdata;
	logic [31:0] next_prdata;
	logic        sel;
	logic        next_sel;
	logic        ind;
	logic        next_ind;
	logic        seek_start;
	logic        next_seek_start;
	logic        head_load;
	logic        next_head_load;

	logic        setup;
	logic        access;
	logic        wr_ctrl;
	logic        wr_cmd;
	logic        motor_opt;
	logic [2:0]  jaddr;
	logic [31:0] status_word;

	assign setup     = i_psel && !i_penable;
	// Writes land only at the edge that completes the access phase.
	assign access    = i_psel && i_penable && pready;
	assign wr_ctrl   = access && i_pwrite && (i_paddr == DDCS_CTRL_ADDR);
	assign wr_cmd    = access && i_pwrite && (i_paddr == DDCS_CMD_ADDR);
	assign motor_opt = ctrl[DDCS_CTRL_MOTOR];
	assign jaddr     = ddcs_jumper_addr(ctrl[DDCS_CTRL_JUMPER+:3]);

	always_comb begin
		status_word = 32'h0;
		status_word[DDCS_ST_READY_BIT] = (state == DDCS_S_READY) && !fail;
		status_word[DDCS_ST_ATTN_BIT]  = attn;
		status_word[DDCS_ST_FAIL_BIT]  = fail;
		status_word[DDCS_ST_SEL_BIT]   = sel;
		status_word[DDCS_ST_SPIN_BIT]  = (state != DDCS_S_STOPPED);
		status_word[DDCS_ST_POR_BIT]   = por;
		status_word[DDCS_ST_STOP_BIT]  = (state == DDCS_S_STOPPED);
		status_word[DDCS_ST_SEEKS_LSB+:5] = seeks;
		status_word[DDCS_ST_ADDR_LSB+:3]  = jaddr;
	end

	// APB slave: answers in the access cycle after setup; unmapped addresses error.
	always_comb begin
		next_pready  = setup;
		next_pslverr = 1'b0;
		next_prdata  = 32'h0;
		next_ctrl    = ctrl;
		if (setup) begin
			case (i_paddr)
				DDCS_CTRL_ADDR: begin
					next_prdata = {20'h0, ctrl};
				end
				DDCS_STATUS_ADDR: begin
					next_prdata = status_word;
					next_pslverr = i_pwrite;
				end
				DDCS_CMD_ADDR: begin
					next_prdata = 32'h0;
				end
				default: begin
					next_pslverr = 1'b1;
				end
			endcase
		end
		if (wr_ctrl) begin
			next_ctrl = i_pwdata[11:0];
		end
	end

	// Power-on attention and motor command handling.
	always_comb begin
		next_por       = por;
		next_attn      = attn;
		next_motor_cmd = motor_cmd;
		if (wr_cmd && i_pwdata[DDCS_CMD_CLR_ATTN]) begin
			next_attn = 1'b0;
		end
		if (wr_cmd && i_pwdata[DDCS_CMD_MOTOR_ON] && !attn) begin
			next_motor_cmd = 1'b1;
			next_por       = 1'b0;
		end
		if (!motor_opt) begin
			next_por  = 1'b0;
			next_attn = 1'b0;
		end
	end

	// Spin-up, tuning seeks and head load sequence.
	always_comb begin
		next_state      = state;
		next_seeks      = seeks;
		next_tries      = tries;
		next_busy       = busy;
		next_fail       = fail;
		next_seek_start = 1'b0;
		next_head_load  = 1'b0;
		case (state)
			DDCS_S_STOPPED: begin
				if ((!motor_opt || motor_cmd) && !fail) begin
					next_state = DDCS_S_SPINUP;
				end
			end
			DDCS_S_SPINUP: begin
				if (i_speed_ok) begin
					next_state = DDCS_S_TUNE;
					next_seeks = 5'h0;
				end
			end
			DDCS_S_TUNE: begin
				if (!busy) begin
					next_busy       = 1'b1;
					next_seek_start = 1'b1;
				end else if (i_seek_done) begin
					next_busy  = 1'b0;
					next_seeks = seeks + 5'h1;
					if (seeks == 5'(DDCS_MAX_SEEKS - 1)) begin
						next_state = DDCS_S_LOAD;
						next_tries = 3'h0;
					end
				end
			end
			DDCS_S_LOAD: begin
				if (!busy) begin
					next_busy      = 1'b1;
					next_head_load = 1'b1;
				end else if (i_head_load_ok) begin
					next_busy  = 1'b0;
					next_state = DDCS_S_READY;
				end else if (i_head_load_fail) begin
					next_busy  = 1'b0;
					next_tries = tries + 3'h1;
					if (tries == 3'(DDCS_LOAD_TRIES - 1)) begin
						next_fail  = 1'b1;
						next_state = DDCS_S_STOPPED;
					end
				end
			end
			DDCS_S_READY: begin
				next_state = DDCS_S_READY;
			end
			default: begin
				next_state = DDCS_S_STOPPED;
			end
		endcase
		if (i_rotor_locked || (ospd_cnt == 32'(OVERSPEED_CYC))) begin
			next_fail = 1'b1;
		end
	end

	// Overspeed timer, flash timer, selection and indicator.
	always_comb begin
		next_ospd_cnt  = 32'h0;
		next_flash_cnt = flash_cnt + 22'h1;
		next_flash     = flash;
		if (i_overspeed) begin
			next_ospd_cnt = (ospd_cnt == 32'(OVERSPEED_CYC)) ? ospd_cnt : ospd_cnt + 32'h1;
		end
		if (flash_cnt == 22'(FLASH_CYC - 1)) begin
			next_flash_cnt = 22'h0;
			next_flash     = !flash;
		end
		if (ctrl[DDCS_CTRL_RADIAL] || (ctrl[DDCS_CTRL_FIVE_POS] && ctrl[DDCS_CTRL_JUMPER+:3] > 3'h3)) begin
			next_sel = 1'b1;
		end else begin
			next_sel = i_drive_select[jaddr[1:0]];
		end
		next_ind = fail ? flash : (!ctrl[DDCS_CTRL_TEST] && sel);
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			ctrl       <= DDCS_CTRL_RESET;
			por        <= 1'b1;
			attn       <= 1'b1;
			motor_cmd  <= 1'b0;
			state      <= DDCS_S_STOPPED;
			seeks      <= 5'h0;
			tries      <= 3'h0;
			busy       <= 1'b0;
			fail       <= 1'b0;
			ospd_cnt   <= 32'h0;
			flash_cnt  <= 22'h0;
			flash      <= 1'b0;
			pready     <= 1'b0;
			pslverr    <= 1'b0;
			prdata     <= 32'h0;
			sel        <= 1'b0;
			ind        <= 1'b0;
			seek_start <= 1'b0;
			head_load  <= 1'b0;
		end else begin
			ctrl       <= next_ctrl;
			por        <= next_por;
			attn       <= next_attn;
			motor_cmd  <= next_motor_cmd;
			state      <= next_state;
			seeks      <= next_seeks;
			tries      <= next_tries;
			busy       <= next_busy;
			fail       <= next_fail;
			ospd_cnt   <= next_ospd_cnt;
			flash_cnt  <= next_flash_cnt;
			flash      <= next_flash;
			pready     <= next_pready;
			pslverr    <= next_pslverr;
			prdata     <= next_prdata;
			sel        <= next_sel;
			ind        <= next_ind;
			seek_start <= next_seek_start;
			head_load  <= next_head_load;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_attention    <= 1'b0;
			o_ready        <= 1'b0;
			o_spindle_on   <= 1'b0;
			o_seek_to_zero <= 1'b0;
			o_factory_test <= 1'b0;
			o_serial_mode  <= 1'b0;
		end else begin
			o_attention    <= attn && motor_opt;
			o_ready        <= (state == DDCS_S_READY) && !fail;
			o_spindle_on   <= (state != DDCS_S_STOPPED);
			o_seek_to_zero <= (state == DDCS_S_LOAD);
			o_factory_test <= ctrl[DDCS_CTRL_TEST];
			o_serial_mode  <= ctrl[DDCS_CTRL_SERIAL];
		end
	end

	assign o_pready     = pready;
	assign o_pslverr    = pslverr;
	assign o_prdata     = prdata;
	assign o_selected   = sel;
	assign o_indicator  = ind;
	assign o_seek_start = seek_start;
	assign o_head_load  = head_load;
endmodule

/* test/ddcs_servo_model.sv */
// Servo and spindle model that answers the drive's start-up controller.
// Assumes the controller's outputs change on the rising edge of i_clk.
`timescale 1ns/1ps
module ddcs_servo_model (
	input  wire logic i_clk,
	input  wire logic i_spindle_on,
	input  wire logic i_seek_start,
	input  wire logic i_head_load,
	input  wire logic i_fail_load,
	output logic      o_speed_ok,
	output logic      o_seek_done,
	output logic      o_load_ok,
	output logic      o_load_fail
);
	logic [2:0] spin_cnt = 3'h0;
	logic [2:0] seek_cnt = 3'h0;
	logic [1:0] load_cnt = 2'h0;
	// Speed is in tolerance a few cycles after the spindle starts.
	always @(posedge i_clk) begin
		spin_cnt <= !i_spindle_on ? 3'h0 : (spin_cnt == 3'h5 ? spin_cnt : spin_cnt + 3'h1);
		o_speed_ok <= i_spindle_on && spin_cnt >= 3'h4;
	end
	// Each tuning seek ends three cycles after it starts.
	always @(posedge i_clk) begin
		seek_cnt <= (i_seek_start === 1'b1) ? 3'h3 : (seek_cnt != 3'h0 ? seek_cnt - 3'h1 : 3'h0);
		o_seek_done <= seek_cnt == 3'h1;
	end
	// A head load attempt answers two cycles later.
	always @(posedge i_clk) begin
		load_cnt <= (i_head_load === 1'b1) ? 2'h2 : (load_cnt != 2'h0 ? load_cnt - 2'h1 : 2'h0);
		o_load_ok <= load_cnt == 2'h1 && !i_fail_load;
		o_load_fail <= load_cnt == 2'h1 && i_fail_load;
	end
endmodule

/* test/ddcs_top_properties.sv */
// Concurrent checks on the ports of the start-up controller.
// Assumes one clock i_clk and synchronous active-high reset i_srst.
`timescale 1ns/1ps
module ddcs_checker #(
	parameter longint OVERSPEED_CYC = 50
) (
	input wire logic        i_clk,
	input wire logic        i_srst,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        o_pready,
	input wire logic [31:0] o_prdata,
	input wire logic        i_speed_ok,
	input wire logic        i_overspeed,
	input wire logic        o_ready,
	input wire logic        o_spindle_on,
	input wire logic        o_seek_start,
	input wire logic        o_selected,
	input wire logic        o_factory_test,
	input wire logic        o_indicator
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);
	logic [31:0] os_cnt;
	logic [31:0] next_os_cnt;
	always_comb begin
		next_os_cnt = i_overspeed ? os_cnt + 32'h1 : 32'h0;
	end
	always_ff @(posedge i_clk) begin
		os_cnt <= i_srst ? 32'h0 : next_os_cnt;
	end
	chk_apb_answer: assert property (i_psel && !i_penable |=> o_pready)
		else $error("pready missing after setup");
	chk_pready_pulse: assert property (o_pready |=> !o_pready)
		else $error("pready longer than one cycle");
	chk_rdata_idle: assert property (!o_pready |-> o_prdata == 32'h0)
		else $error("read data outside answer");
	chk_ready_spin: assert property (o_ready |-> o_spindle_on)
		else $error("ready with spindle stopped");
	chk_seek_speed: assert property (o_seek_start |-> i_speed_ok)
		else $error("tuning seek before speed in tolerance");
	chk_seek_pulse: assert property (o_seek_start |=> !o_seek_start)
		else $error("seek start not a pulse");
	chk_overspeed_fail: assert property (os_cnt > OVERSPEED_CYC + 3 |-> !o_ready)
		else $error("ready kept through long overspeed");
	chk_indicator_sel: assert property (
		o_ready && $stable(o_selected) && $stable(o_factory_test)
		|-> o_indicator == (o_selected && !o_factory_test))
		else $error("indicator differs from selection");
	cover property (o_ready);
	cover property (o_seek_start);
	cover property (os_cnt > OVERSPEED_CYC);
endmodule
bind ddcs_top ddcs_checker #(.OVERSPEED_CYC(OVERSPEED_CYC)) i_ddcs_checker (
	.i_clk(i_clk), .i_srst(i_srst), .i_psel(i_psel), .i_penable(i_penable),
	.o_pready(o_pready), .o_prdata(o_prdata), .i_speed_ok(i_speed_ok),
	.i_overspeed(i_overspeed), .o_ready(o_ready), .o_spindle_on(o_spindle_on),
	.o_seek_start(o_seek_start), .o_selected(o_selected),
	.o_factory_test(o_factory_test), .o_indicator(o_indicator));

/* test/ddcs_top_tb.sv */
// Self-checking bench for the start-up controller, driving APB and a servo model.
// Assumes a 10 MHz clock and shortened overspeed and flash counts.
`timescale 1ns/1ps
module ddcs_top_tb;
	import ddcs_pkg::*;
	logic i_clk = 0, i_srst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
	logic [11:0] i_paddr = 12'h000;
	logic [31:0] i_pwdata = 32'h0, rdat;
	logic [3:0] i_drive_select = 4'h0;
	logic i_overspeed = 0, i_rotor_locked = 0, fail_load = 0, rerr, ind;
	logic i_speed_ok, i_seek_done, load_ok, load_fail, o_pready, o_pslverr;
	logic [31:0] o_prdata;
	logic o_attention, o_ready, o_selected, o_spindle_on, o_seek_start;
	logic o_seek_to_zero, o_head_load, o_indicator, o_factory_test, o_serial_mode;
	int fails = 0, num_checks = 0, seeks = 0, loads = 0;
	logic [31:0] ctl [6] = '{32'h24, 32'h24, 32'h25, 32'h94, 32'h27, 32'h2c};
	logic [3:0] sel [6] = '{4'h2, 4'h1, 4'h0, 4'h0, 4'h0, 4'h2};
	logic [3:0] ex [6] = '{4'h3, 4'h0, 4'h3, 4'h3, 4'h5, 4'hb};
	ddcs_top #(.OVERSPEED_CYC(50), .FLASH_CYC(4)) i_ddcs_top (.i_clk(i_clk), .i_srst(i_srst),
		.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
		.i_pwdata(i_pwdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_prdata(o_prdata),
		.i_drive_select(i_drive_select), .i_speed_ok(i_speed_ok), .i_overspeed(i_overspeed),
		.i_rotor_locked(i_rotor_locked), .i_seek_done(i_seek_done), .i_head_load_ok(load_ok),
		.i_head_load_fail(load_fail), .o_attention(o_attention), .o_ready(o_ready),
		.o_selected(o_selected), .o_spindle_on(o_spindle_on), .o_seek_start(o_seek_start),
		.o_seek_to_zero(o_seek_to_zero), .o_head_load(o_head_load), .o_indicator(o_indicator),
		.o_factory_test(o_factory_test), .o_serial_mode(o_serial_mode));
	ddcs_servo_model i_ddcs_servo_model (.i_clk(i_clk), .i_spindle_on(o_spindle_on),
		.i_seek_start(o_seek_start), .i_head_load(o_head_load), .i_fail_load(fail_load),
		.o_speed_ok(i_speed_ok), .o_seek_done(i_seek_done), .o_load_ok(load_ok),
		.o_load_fail(load_fail));
	initial begin
		forever #50 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		seeks <= i_srst ? 0 : seeks + (o_seek_start === 1'b1);
		loads <= i_srst ? 0 : loads + (o_head_load === 1'b1 && o_seek_to_zero === 1'b1);
	end
	task complete_run;
		$display("Checks %0d, mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task chk(input logic c, input string m);
		num_checks++;
		if (c !== 1'b1) begin
			fails++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_clk);
		{i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge i_clk);
		i_penable <= 1'b1;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_pready !== 1'b1 && n < 20);
		if (o_pready !== 1'b1) begin
			chk(0, "apb timeout");
			complete_run();
		end
		rdat = o_prdata;
		rerr = o_pslverr;
		{i_psel, i_penable} <= 2'b00;
	endtask
	task do_reset;
		@(posedge i_clk);
		i_srst <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_srst <= 1'b0;
	endtask
	initial begin
		repeat (2) @(posedge i_clk);
		i_srst <= 1'b0;
		apb(1, DDCS_CTRL_ADDR, 32'h24);
		repeat (10) @(negedge i_clk);
		chk(o_spindle_on === 0 && o_attention === 1, "spun or no attention");
		apb(0, DDCS_STATUS_ADDR, 0);
		chk(rdat[9:8] === 2'b11 && rdat[1] === 1, "power-on status");
		apb(1, DDCS_CMD_ADDR, 32'h2);
		repeat (10) @(negedge i_clk);
		chk(o_spindle_on === 0, "motor on accepted under attention");
		apb(1, DDCS_CMD_ADDR, 32'h1);
		repeat (2) @(negedge i_clk);
		chk(o_attention === 0, "attention not cleared");
		apb(1, DDCS_CMD_ADDR, 32'h2);
		for (int i = 0; i < 1000 && o_ready !== 1; i++) @(negedge i_clk);
		chk(o_ready === 1 && seeks == DDCS_MAX_SEEKS && loads == 1, "ready or seeks");
		apb(0, DDCS_STATUS_ADDR, 0);
		chk(rdat[0] === 1 && rdat[20:16] === 5'd20 && rdat[8] === 0, "status");
		$display("Test start-up done");
		for (int i = 0; i < 6; i++) begin
			apb(1, DDCS_CTRL_ADDR, ctl[i]);
			i_drive_select <= sel[i];
			repeat (3) @(negedge i_clk);
			chk({o_serial_mode, o_factory_test, o_indicator, o_selected} === ex[i],
				"select decode");
		end
		apb(0, 12'h00c, 0);
		chk(rerr === 1, "unmapped read");
		apb(1, DDCS_STATUS_ADDR, 32'h0);
		chk(rerr === 1, "status write");
		$display("Test selection and access done");
		i_overspeed <= 1'b1;
		repeat (60) @(negedge i_clk);
		ind = o_indicator;
		repeat (4) @(negedge i_clk);
		chk(o_indicator !== ind, "no flash on overspeed");
		apb(0, DDCS_STATUS_ADDR, 0);
		chk(rdat[2] === 1, "overspeed fail");
		i_overspeed <= 1'b0;
		do_reset();
		i_rotor_locked <= 1'b1;
		repeat (8) @(negedge i_clk);
		apb(0, DDCS_STATUS_ADDR, 0);
		chk(rdat[2] === 1 && o_ready === 0, "locked rotor fail");
		i_rotor_locked <= 1'b0;
		fail_load <= 1'b1;
		do_reset();
		apb(1, DDCS_CTRL_ADDR, 32'h20);
		repeat (400) @(negedge i_clk);
		apb(0, DDCS_STATUS_ADDR, 0);
		chk(rdat[2] === 1 && o_ready === 0 && loads == DDCS_LOAD_TRIES, "head load fail");
		$display("Test failures done");
		complete_run();
	end
endmodule
